// file: design/prstc_latch.sv
//------------------------------------------------------------------------------
// One latching status bit, high- or low-latching, cleared by a register read.
//------------------------------------------------------------------------------
module prstc_latch #(
	parameter bit LATCH_LOW = 1'b0
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Condition and read clear.
	input  wire logic cond,
	input  wire logic clr,
	// Held value.
	output logic      held
);

	logic next_held;

	// The event always wins over a clear in the same cycle, so nothing is lost.
	assign next_held = LATCH_LOW ? (cond & (held | clr)) : (cond | (held & ~clr));

	// Storage of the held value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held <= 1'b0;
		end else begin
			held <= next_held;
		end
	end

endmodule : prstc_latch

// file: design/prstc_rst_sync.sv
//------------------------------------------------------------------------------
// Reset release synchroniser: asserts at once, releases after two edges.
//------------------------------------------------------------------------------
module prstc_rst_sync (
	// Clock and raw reset.
	input  wire logic clk,
	input  wire logic resetn,
	// Synchronised reset.
	output logic      rst_n
);

	logic stage;

	// Only the first stage takes a constant; the second copies it, so release is glitch free.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			stage <= 1'b1;
			rst_n <= stage;
		end
	end

endmodule : prstc_rst_sync

// file: design/prstc_top.sv
//------------------------------------------------------------------------------
// Quick-poll status and 10Base-T operations registers behind the MDIO pins.
//------------------------------------------------------------------------------
module prstc_top #(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic resetn,
	// Serial management interface.
	input  wire logic mdc,
	input  wire logic mdio_in,
	output logic      mdio_out,
	output logic      mdio_oe,
	// Mode and negotiation state.
	input  wire logic speed_100,
	input  wire logic an_enable,
	input  wire logic an_done,
	input  wire logic partner_regs_valid,
	// 100Base receive path events.
	input  wire logic rx_signal_lost,
	input  wire logic pll_lock_fail,
	input  wire logic carrier_eval_done,
	input  wire logic carrier_jk_valid,
	input  wire logic rx_in_packet,
	input  wire logic sym_strobe,
	input  wire logic sym_invalid,
	input  wire logic sym_halt,
	input  wire logic sym_idle,
	input  wire logic signal_present,
	// Link, fault, jabber and polarity state.
	input  wire logic link_ok,
	input  wire logic remote_fault,
	input  wire logic tx_jabber,
	input  wire logic rx_jabber_seen,
	input  wire logic polarity_swapped,
	// Toward the MAC.
	output logic      mac_rx_error,
	// 10Base-T controls.
	output logic      jabber_check_inhibit,
	output logic      auto_polarity_inhibit,
	output logic      sqe_test_inhibit,
	output logic      link_loss_inhibit,
	output logic      squelch_inhibit
);

	//--------------------------------------------------------------------------
	// Reset, pin sampling and frame state.
	//--------------------------------------------------------------------------
	logic                         rst_n;
	logic                         mdc_q;
	prstc_pkg::prstc_mdio_state_t state;
	logic [5:0]                   cnt;
	logic [5:0]                   ones;
	logic [1:0]                   op;
	logic [4:0]                   phy;
	logic [4:0]                   regad;
	logic [15:0]                  shift;
	logic                         rd_hit;
	logic                         wr_hit;
	logic [13:0]                  ops;
	logic                         prev_idle;
	logic [prstc_pkg::PRSTC_NUM_LH-1:0] lh;
	logic [prstc_pkg::PRSTC_NUM_LH-1:0] ev;
	logic [prstc_pkg::PRSTC_NUM_LH-1:0] lh_clr;
	logic                         link_held;

	prstc_rst_sync u_rst_sync (
		.clk    (clk),
		.resetn (resetn),
		.rst_n  (rst_n)
	);

	//--------------------------------------------------------------------------
	// Event decode.
	//--------------------------------------------------------------------------
	wire logic mdc_rise   = mdc & ~mdc_q;
	wire logic in_pkt_sym = speed_100 & sym_strobe & rx_in_packet;
	wire logic link_cond;

	// The 100Base flags are gated off in 10Base-T mode, where they mean nothing.
	assign ev[0] = speed_100 & rx_signal_lost;
	assign ev[1] = speed_100 & pll_lock_fail;
	assign ev[2] = speed_100 & carrier_eval_done & ~carrier_jk_valid;
	assign ev[3] = in_pkt_sym & sym_invalid;
	assign ev[4] = in_pkt_sym & sym_halt;
	assign ev[5] = in_pkt_sym & sym_idle & prev_idle;
	assign ev[6] = ~speed_100 & tx_jabber & ~ops[prstc_pkg::PRSTC_OPS_JAB_INH];
	assign ev[7] = remote_fault;
	assign ev[8] = rx_jabber_seen;

	// A forced link pass only applies to the 10Base-T link.
	assign link_cond = speed_100 ? link_ok : (link_ok | ops[prstc_pkg::PRSTC_OPS_LLOSS_INH]);

	// Track the previous in-packet symbol so two idles in a row can be seen.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_idle <= 1'b0;
		end else if (!rx_in_packet) begin
			prev_idle <= 1'b0;
		end else if (sym_strobe) begin
			prev_idle <= sym_idle;
		end
	end

	// The MAC sees invalid and halt symbols on its receive error line.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mac_rx_error <= 1'b0;
		end else begin
			mac_rx_error <= ev[3] | ev[4];
		end
	end

	//--------------------------------------------------------------------------
	// Latching bits.
	//--------------------------------------------------------------------------
	wire logic next_is_qp;
	wire logic next_is_ops;
	wire logic phy_match;
	wire logic reg_final;
	wire logic clr_qp;
	wire logic clr_ops;
	wire logic [4:0] next_regad;

	assign next_regad  = {regad[3:0], mdio_in};
	assign phy_match   = (phy == PHY_ADDR);
	assign next_is_qp  = (next_regad == prstc_pkg::PRSTC_REG_QUICK_POLL);
	assign next_is_ops = (next_regad == prstc_pkg::PRSTC_REG_TENBASE_OPS);
	assign reg_final   = mdc_rise & (state == prstc_pkg::PRSTC_ST_REG)
	                   & (cnt == prstc_pkg::PRSTC_ADDR_LAST) & phy_match
	                   & (op == prstc_pkg::PRSTC_OP_READ);
	// The clear lands in the same cycle as the snapshot, so the read sees history.
	assign clr_qp      = reg_final & next_is_qp;
	assign clr_ops     = reg_final & next_is_ops;
	assign lh_clr      = {clr_ops, {(prstc_pkg::PRSTC_NUM_LH-1){clr_qp}}};

	// One high-latching cell per event flag.
	genvar gi;
	generate
		for (gi = 0; gi < prstc_pkg::PRSTC_NUM_LH; gi++) begin : g_lh
			prstc_latch #(
				.LATCH_LOW (1'b0)
			) u_lh (
				.clk   (clk),
				.rst_n (rst_n),
				.cond  (ev[gi]),
				.clr   (lh_clr[gi]),
				.held  (lh[gi])
			);
		end
	endgenerate

	// Link status latches low, as the basic status link bit does.
	prstc_latch #(
		.LATCH_LOW (1'b1)
	) u_link (
		.clk   (clk),
		.rst_n (rst_n),
		.cond  (link_cond),
		.clr   (clr_qp),
		.held  (link_held)
	);

	//--------------------------------------------------------------------------
	// Read data assembly.
	//--------------------------------------------------------------------------
	wire logic [15:0] rd_qp;
	wire logic [15:0] rd_ops;
	wire logic        an_complete;
	wire logic        sig_detect;

	assign an_complete = an_enable & an_done & partner_regs_valid;
	assign sig_detect  = speed_100 & signal_present;
	// Rate, duplex and progress bits live elsewhere and read as zero here.
	assign rd_qp  = {5'h00, lh[0], lh[1], lh[2], lh[3], lh[4], lh[5],
	                 an_complete, sig_detect, lh[6], lh[7], link_held};
	assign rd_ops = {lh[8], polarity_swapped, ops};

	//--------------------------------------------------------------------------
	// Management frame engine, advanced on each sampled MDC rising edge.
	//--------------------------------------------------------------------------
	wire logic [15:0] wdata = {shift[14:0], mdio_in};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= mdc;
		end
	end

	// Preamble suppression is not supported: every frame needs the full preamble.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= prstc_pkg::PRSTC_ST_PRE;
			cnt      <= 6'h00;
			ones     <= 6'h00;
			op       <= 2'h0;
			phy      <= 5'h00;
			regad    <= 5'h00;
			shift    <= 16'h0000;
			rd_hit   <= 1'b0;
			wr_hit   <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe  <= 1'b0;
		end else if (mdc_rise) begin
			case (state)
				prstc_pkg::PRSTC_ST_PRE: begin
					if (mdio_in) begin
						ones <= (ones == prstc_pkg::PRSTC_PREAMBLE_LEN) ? ones : ones + 6'h01;
					end else if (ones == prstc_pkg::PRSTC_PREAMBLE_LEN) begin
						state <= prstc_pkg::PRSTC_ST_START;
					end else begin
						ones <= 6'h00;
					end
				end
				prstc_pkg::PRSTC_ST_START: begin
					ones  <= 6'h00;
					cnt   <= 6'h00;
					state <= mdio_in ? prstc_pkg::PRSTC_ST_OP : prstc_pkg::PRSTC_ST_PRE;
				end
				prstc_pkg::PRSTC_ST_OP: begin
					op  <= {op[0], mdio_in};
					cnt <= cnt + 6'h01;
					if (cnt == prstc_pkg::PRSTC_OP_LAST) begin
						cnt   <= 6'h00;
						state <= prstc_pkg::PRSTC_ST_PHY;
					end
				end
				prstc_pkg::PRSTC_ST_PHY: begin
					phy <= {phy[3:0], mdio_in};
					cnt <= cnt + 6'h01;
					if (cnt == prstc_pkg::PRSTC_ADDR_LAST) begin
						cnt   <= 6'h00;
						state <= prstc_pkg::PRSTC_ST_REG;
					end
				end
				prstc_pkg::PRSTC_ST_REG: begin
					regad <= next_regad;
					cnt   <= cnt + 6'h01;
					if (cnt == prstc_pkg::PRSTC_ADDR_LAST) begin
						cnt    <= 6'h00;
						state  <= prstc_pkg::PRSTC_ST_TA;
						rd_hit <= reg_final & (next_is_qp | next_is_ops);
						wr_hit <= phy_match & next_is_ops & (op == prstc_pkg::PRSTC_OP_WRITE);
						shift  <= next_is_qp ? rd_qp : rd_ops;
					end
				end
				prstc_pkg::PRSTC_ST_TA: begin
					cnt <= cnt + 6'h01;
					if (cnt == prstc_pkg::PRSTC_TA_LAST) begin
						cnt   <= 6'h00;
						state <= prstc_pkg::PRSTC_ST_DATA;
						if (rd_hit) begin
							mdio_out <= shift[15];
							shift    <= {shift[14:0], 1'b0};
						end
					end else if (rd_hit) begin
						mdio_oe  <= 1'b1;
						mdio_out <= 1'b0;
					end
				end
				prstc_pkg::PRSTC_ST_DATA: begin
					cnt <= cnt + 6'h01;
					if (rd_hit) begin
						mdio_out <= shift[15];
						shift    <= {shift[14:0], 1'b0};
					end else begin
						shift <= wdata;
					end
					if (cnt == prstc_pkg::PRSTC_DATA_LAST) begin
						state    <= prstc_pkg::PRSTC_ST_PRE;
						cnt      <= 6'h00;
						ones     <= 6'h00;
						rd_hit   <= 1'b0;
						wr_hit   <= 1'b0;
						mdio_oe  <= 1'b0;
						mdio_out <= 1'b0;
					end
				end
				default: begin
					state <= prstc_pkg::PRSTC_ST_PRE;
				end
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// 10Base-T operations control storage.
	//--------------------------------------------------------------------------
	wire logic ops_write = mdc_rise & wr_hit & (state == prstc_pkg::PRSTC_ST_DATA)
	                     & (cnt == prstc_pkg::PRSTC_DATA_LAST);

	// Reserved bits are stored as written; software is expected to keep them at default.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ops <= prstc_pkg::PRSTC_OPS_RESET;
		end else if (ops_write) begin
			ops <= wdata[13:0];
		end
	end

	// Controls leave straight from the stored bits.
	assign jabber_check_inhibit  = ops[prstc_pkg::PRSTC_OPS_JAB_INH];
	assign auto_polarity_inhibit = ops[prstc_pkg::PRSTC_OPS_APOL_INH];
	assign sqe_test_inhibit      = ops[prstc_pkg::PRSTC_OPS_SQE_INH];
	assign link_loss_inhibit     = ops[prstc_pkg::PRSTC_OPS_LLOSS_INH];
	assign squelch_inhibit       = ops[prstc_pkg::PRSTC_OPS_SQL_INH];

	//--------------------------------------------------------------------------
	// Assertions.
	//--------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_lost_sets: assert property (ev[0] |=> lh[0] && rd_qp[prstc_pkg::PRSTC_QP_SIG_LOST])
		else $error("signal lost flag not set");
	a_lost_holds: assert property (lh[0] && !clr_qp |=> lh[0])
		else $error("signal lost flag dropped without read");
	a_lock_sets: assert property (speed_100 && pll_lock_fail |=> lh[1])
		else $error("lock error flag not set");
	a_fc_sets: assert property (speed_100 && carrier_eval_done && !carrier_jk_valid |=> lh[2])
		else $error("false carrier flag not set");
	a_inv_mac: assert property (in_pkt_sym && sym_invalid |=> mac_rx_error && lh[3])
		else $error("invalid symbol not reported");
	a_halt_mac: assert property (in_pkt_sym && sym_halt |=> mac_rx_error && lh[4])
		else $error("halt symbol not reported");
	a_prem_end: assert property (in_pkt_sym && sym_idle ##1 (rx_in_packet && !sym_strobe)[*2]
		##1 in_pkt_sym && sym_idle |=> lh[5])
		else $error("premature end not latched");
	a_ten_quiet: assert property (!speed_100 && !lh[0] && !lh[3] |=> !lh[0] && !lh[3])
		else $error("100Base flag set in 10Base-T mode");
	a_an_gate: assert property (!an_enable || !an_done || !partner_regs_valid
		|-> !rd_qp[prstc_pkg::PRSTC_QP_AN_DONE])
		else $error("negotiation complete while not finished");
	a_sd_live: assert property (speed_100 && signal_present ##1 speed_100 && !signal_present
		|-> !rd_qp[prstc_pkg::PRSTC_QP_SIG_DET])
		else $error("signal detect latched");
	a_link_pass: assert property (!speed_100 && link_loss_inhibit && link_held
		|=> link_held || speed_100)
		else $error("forced link pass dropped");
	a_rjab_clr: assert property (clr_ops && !rx_jabber_seen |=> !lh[8])
		else $error("remote jabber not cleared on read");
	a_read_hist: assert property (clr_qp |=> lh[0] == $past(ev[0]))
		else $error("latched bit not returned to present state");
	a_ctrl_write: assert property (ops_write |=> sqe_test_inhibit == $past(wdata[2])
		&& auto_polarity_inhibit == $past(wdata[3]))
		else $error("control bits not updated by write");

endmodule : prstc_top

// file: dv/prstc_sme.sv
//------------------------------------------------------------------------------
// Station management entity that runs management frames against the block.
//------------------------------------------------------------------------------
module prstc_sme (
	// Bench clock.
	input  wire logic clk,
	// Management pins.
	output logic      mdc,
	output logic      mdio_drv,
	output logic      mdio_en,
	input  wire logic mdio_wire
);
	timeunit 1ns;
	timeprecision 1ps;

	// The clock is parked low and the data line released between frames.
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b0;
		mdio_en = 1'b0;
	end

	// One whole frame, eight bench clocks per management clock period: low for three, high for five.
	// The line is let go from the first turnaround bit of a read to avoid a clash.
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'b01, op, phy, rg, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++) begin
			@(negedge clk);
			mdc = 1'b0;
			mdio_en = !(op == prstc_pkg::PRSTC_OP_READ && i >= 46);
			mdio_drv = bits[63 - i];
			repeat (3) @(negedge clk);
			if (i >= 48) begin
				rd = {rd[14:0], mdio_wire};
			end
			mdc = 1'b1;
			repeat (4) @(negedge clk);
		end
		@(negedge clk);
		mdc = 1'b0;
		mdio_en = 1'b0;
	endtask : frame
endmodule : prstc_sme

// file: dv/tb.sv
//------------------------------------------------------------------------------
// Self-checking bench for the status and operations registers.
//------------------------------------------------------------------------------
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] QP  = prstc_pkg::PRSTC_REG_QUICK_POLL;
	localparam logic [4:0] OPS = prstc_pkg::PRSTC_REG_TENBASE_OPS;
	localparam logic [1:0] RD  = prstc_pkg::PRSTC_OP_READ;
	localparam logic [1:0] WR  = prstc_pkg::PRSTC_OP_WRITE;
	logic clk, resetn, mdc, mdio_in, mdio_out, mdio_oe, mdio_drv, mdio_en;
	logic speed_100, an_enable, an_done, partner_regs_valid, rx_signal_lost, pll_lock_fail;
	logic carrier_eval_done, carrier_jk_valid, rx_in_packet, sym_strobe, sym_invalid;
	logic sym_halt, sym_idle, signal_present, link_ok, remote_fault, tx_jabber;
	logic rx_jabber_seen, polarity_swapped, mac_rx_error, jabber_check_inhibit;
	logic auto_polarity_inhibit, sqe_test_inhibit, link_loss_inhibit, squelch_inhibit, rxe;
	logic [4:0] c;
	logic [15:0] w;
	int   fail_count, samples_checked;

	prstc_top i_prstc_top (.clk, .resetn, .mdc, .mdio_in, .mdio_out, .mdio_oe, .speed_100,
		.an_enable, .an_done, .partner_regs_valid, .rx_signal_lost, .pll_lock_fail,
		.carrier_eval_done, .carrier_jk_valid, .rx_in_packet, .sym_strobe, .sym_invalid,
		.sym_halt, .sym_idle, .signal_present, .link_ok, .remote_fault, .tx_jabber,
		.rx_jabber_seen, .polarity_swapped, .mac_rx_error, .jabber_check_inhibit,
		.auto_polarity_inhibit, .sqe_test_inhibit, .link_loss_inhibit, .squelch_inhibit);
	prstc_sme i_prstc_sme (.clk, .mdc, .mdio_drv, .mdio_en, .mdio_wire(mdio_in));

	// The data line has a pull-up, so a released line reads one.
	assign mdio_in = mdio_oe ? mdio_out : (mdio_en ? mdio_drv : 1'b1);

	// Free-running 200 MHz clock.
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	task automatic summarize();
		if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Expected quick-poll value after event k: its own flag for k below 8, plus the link unless k drops it.
	function automatic logic [15:0] exp_event(input int k);
		logic [15:0] v;
		v = 16'h0000;
		if (k < 6) v[prstc_pkg::PRSTC_QP_SIG_LOST - k] = 1'b1;
		else if (k < 8) v[prstc_pkg::PRSTC_QP_JABBER + 6 - k] = 1'b1;
		v[prstc_pkg::PRSTC_QP_LINK] = (k != 9);
		return v;
	endfunction : exp_event

	// Expected live quick-poll bits for mode vector {speed, signal, enable, done, valid}.
	function automatic logic [15:0] exp_live(input logic [4:0] m);
		logic [15:0] v;
		v = 16'h0001;
		v[prstc_pkg::PRSTC_QP_AN_DONE] = &m[2:0];
		v[prstc_pkg::PRSTC_QP_SIG_DET] = m[4] & m[3];
		return v;
	endfunction : exp_live

	// A read compares against the value passed in; a write just sends it.
	task automatic acc(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] d);
		logic [15:0] r;
		i_prstc_sme.frame(op, phy, rg, d, r);
		if (op == RD) check("mdio read", r, d);
	endtask : acc

	// One-cycle event; the receive error toward the MAC is watched for two cycles.
	task automatic pulse(input int k, output logic seen);
		@(negedge clk);
		case (k)
			0: rx_signal_lost = 1'b1;
			1: pll_lock_fail = 1'b1;
			2: carrier_eval_done = 1'b1;
			3: {sym_strobe, sym_invalid} = 2'b11;
			4: {sym_strobe, sym_halt} = 2'b11;
			5: {sym_strobe, sym_idle} = 2'b11;
			6: tx_jabber = 1'b1;
			7: remote_fault = 1'b1;
			8: rx_jabber_seen = 1'b1;
			default: link_ok = 1'b0;
		endcase
		@(negedge clk);
		seen = mac_rx_error;
		{rx_signal_lost, pll_lock_fail, carrier_eval_done, sym_strobe, sym_invalid} = '0;
		{sym_halt, sym_idle, tx_jabber, remote_fault, rx_jabber_seen} = '0;
		link_ok = 1'b1;
		@(negedge clk);
		seen = seen | mac_rx_error;
	endtask : pulse

	// Hang guard, well beyond the length of the sequence below.
	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		summarize();
	end

	// Main sequence.
	initial begin
		{resetn, speed_100, an_enable, an_done, partner_regs_valid, rx_signal_lost} = '0;
		{pll_lock_fail, carrier_eval_done, carrier_jk_valid, rx_in_packet, sym_strobe} = '0;
		{sym_invalid, sym_halt, sym_idle, signal_present, remote_fault, tx_jabber} = '0;
		{rx_jabber_seen, polarity_swapped} = '0;
		link_ok = 1'b1;
		void'($urandom(32'hF9B4D15D));
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		acc(RD, 5'h00, OPS, 16'h0010);
		acc(RD, 5'h00, QP, 16'h0000);
		acc(RD, 5'h00, QP, 16'h0001);
		// Control writes, all-ones and all-zeros first, then random ones.
		for (int i = 0; i < 6; i++) begin
			c = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : 5'($urandom);
			w = {2'b11, 8'h00, c[4], 1'b1, c[3:0]};
			acc(WR, 5'h00, OPS, w);
			check("controls", {11'h000, jabber_check_inhibit, auto_polarity_inhibit, sqe_test_inhibit,
				link_loss_inhibit, squelch_inhibit}, {11'h000, c});
			acc(RD, 5'h00, OPS, {2'b00, w[13:0]});
		end
		// Jabber check and link loss both inhibited in 10 mode.
		acc(WR, 5'h00, OPS, 16'h0032);
		link_ok = 1'b0;
		pulse(6, rxe);
		// The first five 100Base events must leave no trace while in 10Base-T mode.
		rx_in_packet = 1'b1;
		for (int k = 0; k < 5; k++) begin
			pulse(k, rxe);
		end
		rx_in_packet = 1'b0;
		check("rx error", {15'h0000, rxe}, 16'h0000);
		link_ok = 1'b0;
		repeat (2) @(negedge clk);
		acc(RD, 5'h00, QP, 16'h0001);
		link_ok = 1'b1;
		acc(WR, 5'h00, OPS, 16'h0010);
		// Near misses: symbol outside a packet, a good delimiter, a lone idle.
		speed_100 = 1'b1;
		carrier_jk_valid = 1'b1;
		pulse(3, rxe);
		check("rx error", {15'h0000, rxe}, 16'h0000);
		pulse(2, rxe);
		rx_in_packet = 1'b1;
		pulse(5, rxe);
		rx_in_packet = 1'b0;
		acc(RD, 5'h00, QP, 16'h0001);
		carrier_jk_valid = 1'b0;
		rx_in_packet = 1'b1;
		// Each latching event, then the read that clears it.
		for (int k = 0; k < 10; k++) begin
			speed_100 = (k < 6);
			repeat (4) @(negedge clk);
			if (k == 5) pulse(k, rxe);
			pulse(k, rxe);
			check("rx error", {15'h0000, rxe}, {15'h0000, k == 3 || k == 4});
			acc(RD, 5'h00, QP, exp_event(k));
			acc(RD, 5'h00, QP, 16'h0001);
			if (k == 8) acc(RD, 5'h00, OPS, 16'h8010);
			if (k == 8) acc(RD, 5'h00, OPS, 16'h0010);
		end
		rx_in_packet = 1'b0;
		// Live bits under random mode and negotiation inputs.
		for (int i = 0; i < 8; i++) begin
			c = (i == 0) ? 5'h1F : 5'($urandom);
			{speed_100, signal_present, an_enable, an_done, partner_regs_valid} = c;
			repeat (2) @(negedge clk);
			acc(RD, 5'h00, QP, exp_live(c));
		end
		polarity_swapped = 1'b1;
		repeat (2) @(negedge clk);
		acc(RD, 5'h00, OPS, 16'h4010);
		// Refused frames: foreign address, unmapped register, read-only register.
		acc(WR, 5'h01, OPS, 16'h003F);
		acc(WR, 5'h00, QP, 16'h07FF);
		acc(RD, 5'h01, OPS, 16'hFFFF);
		acc(RD, 5'h00, 5'h13, 16'hFFFF);
		acc(RD, 5'h00, OPS, 16'h4010);
		summarize();
	end
endmodule : tb

// file: pkg/prstc_pkg.sv
//------------------------------------------------------------------------------
// Constants for the quick-poll status and 10Base-T operations registers.
//------------------------------------------------------------------------------
// Behaviour
// - Latch signal-lost high when the 100Base-TX receive signal drops; clear on read.
// - Latch lock-error high when the receive PLL fails to lock; clear on read.
// - Latch false-carrier high when a started evaluation lacks a J/K delimiter pair.
// - An erroneous in-packet symbol raises the MAC receive error and invalid-symbol flag.
// - A halt symbol in a packet is signalled to the MAC and latched.
// - Two consecutive idles inside a packet latch the premature-end flag.
// - The six 100Base receive error flags carry no meaning in 10Base-T mode.
// - Negotiation-complete reads one only when enabled, finished and partner registers valid.
// - In 100Base-TX mode signal-detect follows receive signal presence, not latched.
// - Quick-poll jabber bit behaves as the basic status jabber bit, 10Base-T only.
// - Quick-poll remote-fault bit behaves as the basic status remote-fault bit.
// - Quick-poll link bit behaves as the basic status link bit, latching low.
// - Auto-polarity-inhibit at one stops polarity correction; zero corrects automatically.
// - SQE-test-inhibit at one disables SQE test generation; zero is normal.
// - Link-loss-inhibit at one reports the 10Base-T link as always passed.
// - Remote-jabber latches high on receive jabber, clears on operations register read.
// - Polarity-reversed reads one while receive pins are swapped, else zero.
// - Jabber-inhibit at one skips the transmit jabber check; zero enables it.
// - Squelch-inhibit at one requires valid data then idle before declaring link.
package prstc_pkg;

	//--------------------------------------------------------------------------
	// Register addresses on the management interface.
	//--------------------------------------------------------------------------
	localparam logic [4:0]  PRSTC_REG_QUICK_POLL = 5'h11;
	localparam logic [4:0]  PRSTC_REG_TENBASE_OPS = 5'h12;

	//--------------------------------------------------------------------------
	// Quick-poll status field positions.
	//--------------------------------------------------------------------------
	localparam int          PRSTC_QP_SIG_LOST   = 10;
	localparam int          PRSTC_QP_LOCK_ERR   = 9;
	localparam int          PRSTC_QP_FALSE_CARR = 8;
	localparam int          PRSTC_QP_INV_SYM    = 7;
	localparam int          PRSTC_QP_HALT_SYM   = 6;
	localparam int          PRSTC_QP_PREM_END   = 5;
	localparam int          PRSTC_QP_AN_DONE    = 4;
	localparam int          PRSTC_QP_SIG_DET    = 3;
	localparam int          PRSTC_QP_JABBER     = 2;
	localparam int          PRSTC_QP_RFAULT     = 1;
	localparam int          PRSTC_QP_LINK       = 0;

	//--------------------------------------------------------------------------
	// 10Base-T operations field positions and reset value.
	//--------------------------------------------------------------------------
	localparam int          PRSTC_OPS_RJABBER   = 15;
	localparam int          PRSTC_OPS_POL_REV   = 14;
	localparam int          PRSTC_OPS_JAB_INH   = 5;
	localparam int          PRSTC_OPS_APOL_INH  = 3;
	localparam int          PRSTC_OPS_SQE_INH   = 2;
	localparam int          PRSTC_OPS_LLOSS_INH = 1;
	localparam int          PRSTC_OPS_SQL_INH   = 0;
	localparam logic [13:0] PRSTC_OPS_RESET     = 14'h0010;

	//--------------------------------------------------------------------------
	// Management frame fields and timing.
	//--------------------------------------------------------------------------
	localparam logic [5:0]  PRSTC_PREAMBLE_LEN  = 6'h20;
	localparam logic [1:0]  PRSTC_OP_READ       = 2'h2;
	localparam logic [1:0]  PRSTC_OP_WRITE      = 2'h1;
	localparam logic [5:0]  PRSTC_OP_LAST       = 6'h01;
	localparam logic [5:0]  PRSTC_ADDR_LAST     = 6'h04;
	localparam logic [5:0]  PRSTC_TA_LAST       = 6'h01;
	localparam logic [5:0]  PRSTC_DATA_LAST     = 6'h0F;
	localparam int          PRSTC_NUM_LH        = 9;

	typedef enum logic [2:0] {
		PRSTC_ST_PRE,
		PRSTC_ST_START,
		PRSTC_ST_OP,
		PRSTC_ST_PHY,
		PRSTC_ST_REG,
		PRSTC_ST_TA,
		PRSTC_ST_DATA
	} prstc_mdio_state_t;

endpackage : prstc_pkg
